/* File: inc/vcl_pkg.sv */
// Constants and carrier types for the virtual-axis clutch block
package vcl_pkg;
	// Register word byte addresses
	localparam logic [7:0] VCL_ADR_MODE    = 8'h00;
	localparam logic [7:0] VCL_ADR_CTRL    = 8'h04;
	localparam logic [7:0] VCL_ADR_ON_SET  = 8'h08;
	localparam logic [7:0] VCL_ADR_OFF_SET = 8'h0C;
	localparam logic [7:0] VCL_ADR_STATUS  = 8'h10;
	// Field positions
	localparam int VCL_CTRL_CMD     = 0;
	localparam int VCL_CTRL_ERR_OFF = 1;
	localparam int VCL_ST_CLUTCH    = 0;
	localparam int VCL_ST_FLAG      = 1;
	localparam int VCL_ST_MODE_ERR  = 2;
	localparam int VCL_ST_ERR_HOLD  = 3;
	localparam int VCL_ST_SEQ_BUSY  = 4;
	localparam int VCL_ST_MODE_LSB  = 8;
	// Mode codes
	localparam logic [2:0] VCL_MODE_ONOFF = 3'h0;
	localparam logic [2:0] VCL_MODE_ADR2  = 3'h2;
	localparam logic [2:0] VCL_MODE_OS_ON = 3'h3;
	localparam logic [2:0] VCL_MODE_OS_NO = 3'h4;
	localparam logic [15:0] VCL_MODE_MAX  = 16'h0004;
	// Reset values
	localparam logic [15:0] VCL_MODE_RST  = 16'h0000;
	localparam logic [31:0] VCL_SET_RST   = 32'h0000_0000;

	typedef struct packed {
		logic signed [31:0] on_set;
		logic signed [31:0] off_set;
	} vcl_set_t;

	typedef struct packed {
		logic [7:0]  addr;
		logic [31:0] wdata;
		logic        wr;
		logic        rd;
	} vcl_bus_t;

	typedef enum logic [1:0] {
		VCL_SEQ_IDLE,
		VCL_SEQ_PRE,
		VCL_SEQ_POST
	} vcl_seq_t;
endpackage

/* File: tb/vcl_host_model.sv */
// Controller program model: writes mode, command and settings words
`timescale 1ns/10ps
`default_nettype none
module vcl_host_model
	import vcl_pkg::*;
(
	input  wire logic        clk,
	output var  logic [7:0]  addr,
	output var  logic [31:0] wdata,
	output var  logic        wr,
	output var  logic        rd,
	input  wire logic [31:0] rdata
);
	initial begin
		addr = 8'h00;
		wdata = 32'h0000_0000;
		wr = 1'b0;
		rd = 1'b0;
	end
	// Settings go out as one whole signed 32-bit word
	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		addr <= ~a;
		wdata <= ~d;
	endtask
	task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(negedge clk);
		d = rdata;
	endtask
	// Command drop before servo off, raise again after error clear
	task automatic set_ctrl(input logic cmd, input logic eo);
		wr_reg(VCL_ADR_CTRL, {30'h0, eo, cmd});
	endtask
endmodule
`default_nettype wire

/* File: tb/virtual_clutch_address2_oneshot_bench.sv */
// Self-checking bench for the virtual-axis clutch
`timescale 1ns/10ps
`default_nettype none
module virtual_clutch_address2_oneshot_bench;
	import vcl_pkg::*;
	logic ref_clk = 1'b0, rstn = 1'b0, op_tick = 1'b0, err = 1'b0;
	logic signed [31:0] travel = 32'h0, cur = 32'h0;
	logic [7:0] addr;
	logic [31:0] wdata, rdata, rv;
	logic wr, rd, clutch_on, clutch_status;
	int bad_count = 0, n_compared = 0, seed = 11, cyc = 0, i, k;
	int st = 0, m = 0, m_q = 0;
	logic cmd = 0, cmd_q = 0, eo = 0, hold = 0, ec = 0, cmp = 1;
	longint acc, pre, post, s, sp = 0, sq = 0, lp = 0, lq = 0;
	always #20 ref_clk = ~ref_clk;
	vcl_host_model host (.clk(ref_clk), .addr(addr), .wdata(wdata),
		.wr(wr), .rd(rd), .rdata(rdata));
	vcl_clutch dut (.REF_CLK(ref_clk), .RSTN(rstn), .ADDR(addr),
		.WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .OP_TICK(op_tick),
		.CUR_VALUE(cur), .TRAVEL(travel), .MAJOR_ERR(err),
		.CLUTCH_ON(clutch_on), .CLUTCH_STATUS(clutch_status));
	function automatic bit met(longint a, longint d);
		return d >= 0 ? a >= d : a <= d;
	endfunction
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_compared++;
		if (g !== e) begin
			bad_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic setm(input logic [15:0] v);
		host.wr_reg(VCL_ADR_MODE, {16'h0, v});
		if (v <= VCL_MODE_MAX) m = v;
	endtask
	task automatic setc(input logic c, input logic e);
		host.set_ctrl(c, e);
		cmd = c;
		eo = e;
	endtask
	task automatic sets(input longint p, input longint q);
		host.wr_reg(VCL_ADR_OFF_SET, p[31:0]);
		host.wr_reg(VCL_ADR_ON_SET, q[31:0]);
		sp = p;
		sq = q;
	endtask
	task automatic eval(input longint t);
		if (st == 1) begin
			acc += t;
			t = 0;
			if (met(acc, lp)) begin
				acc -= lp;
				st = 2;
			end
		end
		if (st == 2) begin
			acc += t;
			if (met(acc, lq)) st = 0;
		end
	endtask
	task automatic otick(input logic signed [31:0] t, c, input logic e);
		@(posedge ref_clk);
		op_tick <= 1'b1;
		travel <= t;
		cur <= c;
		err <= e;
		@(posedge ref_clk);
		op_tick <= 1'b0;
		hold = hold ? (e || cmd) : (e && eo);
		if (hold || m < 3) st = 0;
		else if (st != 0) eval(t);
		else if (m == 3 && cmd && (!cmd_q || m_q != 3)) begin
			lp = sp;
			lq = sq;
			acc = 0;
			st = 1;
			eval(0);
		end
		if (m >= 3 || hold) ec = (st == 2);
		cmd_q = cmd;
		m_q = m;
		#1;
		if (cmp) chk({clutch_status, clutch_on}, {ec, ec});
	endtask
	task automatic tally_and_finish;
		$display("compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 30000) begin
			bad_count++;
			tally_and_finish;
		end
	end
	initial begin
		repeat (8) @(posedge ref_clk);
		rstn <= 1'b1;
		chk({clutch_status, clutch_on}, 2'b00);
		// Random one-shot sequences, both directions
		setm(16'h3);
		for (i = 0; i < 30; i++) begin
			s = ($random(seed) & 1) ? -1 : 1;
			pre = s * (($random(seed) & 32'h7FFF) % 7);
			post = s * (1 + ($random(seed) & 32'h7FFF) % 6);
			sets(pre, post);
			setc(1, 0);
			for (k = 0; k < 40 && (k == 0 || st != 0); k++) begin
				otick(s * (($random(seed) & 32'h7FFF) % 4) -
					(k % 5 == 4 ? s : 0), 32'h0, 0);
				if (k == 0) chk(clutch_on, pre == 0);
				if (k == 1) setc(0, 0);
				if (k == 2) sets(-pre, 1);
				if (k == 2 && i % 4 == 3) setm(16'h4);
			end
			if (m == 4) begin
				setc(1, 0);
				otick(32'h7, 32'h0, 0);
				host.rd_reg(VCL_ADR_STATUS, rv);
				chk(rv[VCL_ST_SEQ_BUSY], 1'b0);
				setm(16'h3);
			end
			setc(0, 0);
			otick(32'h0, 32'h0, 0);
		end
		$display("one-shot random done");
		// Illegal mode word keeps the accepted mode
		setm(16'h7);
		otick(32'h0, 32'h0, 0);
		host.rd_reg(VCL_ADR_STATUS, rv);
		chk({rv[10:8], rv[VCL_ST_MODE_ERR]}, {3'h3, 1'b1});
		// Error response, recovery by command low then rise
		sets(0, 100);
		setc(1, 1);
		otick(32'h0, 32'h0, 0);
		otick(32'h5, 32'h0, 1);
		otick(32'h5, 32'h0, 0);
		setc(0, 1);
		otick(32'h0, 32'h0, 0);
		setc(1, 1);
		otick(32'h0, 32'h0, 0);
		chk(clutch_on, 1'b1);
		// Mode 0 holds, mode 3 entry with command low clears
		setm(16'h0);
		setc(0, 0);
		otick(32'h0, 32'h0, 0);
		setm(16'h3);
		otick(32'h0, 32'h0, 0);
		// Mode 3 entry with command already high
		setm(16'h0);
		setc(1, 0);
		otick(32'h0, 32'h0, 0);
		setm(16'h3);
		otick(32'h0, 32'h0, 0);
		setm(16'h0);
		otick(32'h0, 32'h0, 0);
		setm(16'h4);
		otick(32'h0, 32'h0, 0);
		// Address mode 2
		cmp = 0;
		setm(16'h2);
		sets(200, 100);
		host.rd_reg(VCL_ADR_ON_SET, rv);
		chk(rv, 32'd100);
		otick(0, 32'd0, 0);
		// One tick passes ON then OFF: flag must not pulse
		otick(0, 32'd250, 0);
		chk(clutch_status, 1'b0);
		chk(clutch_on, 1'b0);
		otick(0, 32'd150, 0);
		otick(0, 32'd50, 0);
		chk(clutch_on, 1'b1);
		otick(0, 32'd250, 0);
		chk(clutch_on, 1'b0);
		otick(0, 32'd50, 0);
		chk(clutch_status, 1'b1);
		setc(0, 0);
		otick(0, 32'd50, 0);
		chk(clutch_on, 1'b0);
		otick(0, 32'd150, 0);
		chk(clutch_on, 1'b0);
		setc(1, 0);
		otick(0, 32'd50, 0);
		chk(clutch_on, 1'b1);
		$display("mode tests done");
		tally_and_finish;
	end
endmodule
`default_nettype wire

/* File: verilog/vcl_clutch.sv */
// Virtual-axis clutch: address mode 2 and travel-count one-shot mode
// How it works
// - Mode word above 4 is an error; the last accepted mode stays.
// - A new mode word takes effect at the next evaluation.
// - ON and OFF settings are signed 32-bit words, writable any time.
// - Evaluate once per cycle; a pass within one cycle hides the flag.
// - Error response set to off plus major error forces the clutch off.
// - After an error, command low restores; next rise resumes control.
// - Mode 3 is one-shot with command, mode 4 one-shot ignoring it.
// - Mode 3 rise: engage after pre distance, release after post distance.
// - Command falling in one-shot leaves the sequence and clutch alone.
// - Mode 4 keeps clutch off; 3 to 4 finishes the running sequence.
// - Both distances are signed pulses; sign gives the direction.
// - Zero pre distance engages in the same evaluation as the rise.
// - Engage and release within one cycle never shows on the flag.
// - Mode becoming 3 with command high starts a one-shot sequence.
// - Mode becoming 3 with command low and clutch on turns it off.
// - Mode becoming 4 from other than 3 turns the clutch off.
// - Settings written mid-sequence apply only from the next rise.
// - Sequence waits for the full travel, even with the drive stopped.
// - Current value rewrites do not move the release point.
// - Switch points are command position plus distances, net travel.
// - Travel input is the virtual-axis or one-revolution travel.
// - Mode 2, command high: engage at ON address, release at OFF.
// - Mode 2, command low: clutch off, address watching suspended.
`timescale 1ns/10ps
`default_nettype none
module vcl_clutch
	import vcl_pkg::*;
(
	input  wire logic               REF_CLK,
	input  wire logic               RSTN,
	input  wire logic [7:0]         ADDR,
	input  wire logic [31:0]        WDATA,
	input  wire logic               WR,
	input  wire logic               RD,
	output logic      [31:0]        RDATA,
	input  wire logic               OP_TICK,
	input  wire logic signed [31:0] CUR_VALUE,
	input  wire logic signed [31:0] TRAVEL,
	input  wire logic               MAJOR_ERR,
	output logic                    CLUTCH_ON,
	output logic                    CLUTCH_STATUS
);
	vcl_bus_t               bus;
	logic [15:0]            mode_word;
	logic                   cmd;
	logic                   err_off;
	vcl_set_t               setting;
	vcl_set_t               latched;
	logic [2:0]             mode_acc;
	logic                   mode_err;
	logic                   cmd_prev;
	logic                   err_hold;
	logic                   clutch;
	logic                   status;
	logic signed [31:0]     last_cur;
	logic signed [33:0]     acc;
	vcl_seq_t               seq;
	logic [31:0]            rdata;

	logic                   mode_ok;
	logic [2:0]             mode_eval;
	logic                   mode_chg;
	logic                   rise;
	logic                   err_now;
	logic                   err_release;
	logic                   start;
	logic signed [33:0]     acc_sum;
	logic signed [33:0]     acc_post;
	logic signed [33:0]     pre_dist;
	logic signed [33:0]     post_dist;
	logic                   pre_hit;
	logic                   post_hit;
	logic                   on_cross;
	logic                   off_cross;
	logic                   os_mode;
	logic                   moving_up;
	logic                   off_after_on;
	logic                   on_after_off;
	logic                   next_clutch;
	vcl_seq_t               next_seq;
	logic signed [33:0]     next_acc;
	logic                   next_err_hold;
	logic [31:0]            next_rdata;
	logic [31:0]            status_word;
	logic                   wr_mode;
	logic                   wr_ctrl;
	logic                   wr_on;
	logic                   wr_off;

	// True when signed value a has covered signed distance d
	function automatic logic reached(input logic signed [33:0] a,
		input logic signed [33:0] d);
		reached = d[33] ? (a <= d) : (a >= d);
	endfunction

	// True when the current value passed point p since the last tick
	function automatic logic crossed(input logic signed [31:0] from_v,
		input logic signed [31:0] to_v, input logic signed [31:0] p);
		crossed = ((from_v < p) && (p <= to_v)) ||
			((to_v <= p) && (p < from_v));
	endfunction

	assign bus = '{addr: ADDR, wdata: WDATA, wr: WR, rd: RD};

	// Register decode
	assign wr_mode = bus.wr && (bus.addr == VCL_ADR_MODE);
	assign wr_ctrl = bus.wr && (bus.addr == VCL_ADR_CTRL);
	assign wr_on   = bus.wr && (bus.addr == VCL_ADR_ON_SET);
	assign wr_off  = bus.wr && (bus.addr == VCL_ADR_OFF_SET);

	always_ff @(posedge REF_CLK or negedge RSTN) begin
		if (!RSTN) begin
			mode_word <= VCL_MODE_RST;
			cmd       <= 1'b0;
			err_off   <= 1'b0;
			setting   <= '{on_set: VCL_SET_RST, off_set: VCL_SET_RST};
		end else begin
			if (wr_mode)
				mode_word <= bus.wdata[15:0];
			if (wr_ctrl) begin
				cmd     <= bus.wdata[VCL_CTRL_CMD];
				err_off <= bus.wdata[VCL_CTRL_ERR_OFF];
			end
			if (wr_on)
				setting.on_set <= bus.wdata;
			if (wr_off)
				setting.off_set <= bus.wdata;
		end
	end

	// Mode acceptance: an illegal word leaves the previous mode in force
	assign mode_ok   = (mode_word <= VCL_MODE_MAX);
	assign mode_eval = mode_ok ? mode_word[2:0] : mode_acc;
	assign mode_chg  = (mode_eval != mode_acc);
	assign os_mode   = (mode_eval == VCL_MODE_OS_ON) ||
		(mode_eval == VCL_MODE_OS_NO);
	assign rise      = cmd && !cmd_prev;

	// Error response and its release by a low command
	assign err_now       = err_off && MAJOR_ERR;
	assign err_release   = !MAJOR_ERR && !cmd;
	assign next_err_hold = err_now ? 1'b1 :
		(err_release ? 1'b0 : err_hold);

	// A new sequence starts on a rise in mode 3, or on entry to mode 3
	// with the command already high; a running sequence is never restarted
	assign start = !next_err_hold && (mode_eval == VCL_MODE_OS_ON) &&
		(seq == VCL_SEQ_IDLE) && cmd &&
		(rise || (mode_acc != VCL_MODE_OS_ON));

	// Distances widened so the sums cannot wrap
	assign pre_dist  = start ? 34'(setting.off_set) :
		34'(latched.off_set);
	assign post_dist = start ? 34'(setting.on_set) :
		34'(latched.on_set);

	// Net signed travel since the command: reversals cancel and a
	// rewritten current value does not enter the count
	assign acc_sum  = start ? 34'sd0 : (acc + 34'(TRAVEL));
	assign pre_hit  = reached(acc_sum, pre_dist);
	assign acc_post = (seq == VCL_SEQ_POST) ? acc_sum : (acc_sum - pre_dist);
	assign post_hit = reached(acc_post, post_dist);

	// Address mode 2 crossing detection
	assign on_cross  = crossed(last_cur, CUR_VALUE, setting.on_set);
	assign off_cross = crossed(last_cur, CUR_VALUE, setting.off_set);

	// Both addresses passed in one tick: the one met last decides the
	// state, so the short pulse stays internal and never reaches the flag
	assign moving_up    = (CUR_VALUE > last_cur);
	assign off_after_on = moving_up ? (setting.off_set > setting.on_set) :
		(setting.off_set < setting.on_set);
	assign on_after_off = moving_up ? (setting.on_set > setting.off_set) :
		(setting.on_set < setting.off_set);

	always_comb begin
		next_clutch = clutch;
		next_seq    = seq;
		next_acc    = acc;
		if (next_err_hold) begin
			next_clutch = 1'b0;
			next_seq    = VCL_SEQ_IDLE;
		end else if (mode_eval == VCL_MODE_ADR2) begin
			next_seq = VCL_SEQ_IDLE;
			if (!cmd)
				next_clutch = 1'b0;
			else if (!clutch && on_cross)
				next_clutch = !(off_cross && off_after_on);
			else if (clutch && off_cross)
				next_clutch = on_cross && on_after_off;
		end else if (os_mode) begin
			if (mode_eval == VCL_MODE_OS_NO && mode_chg &&
				mode_acc != VCL_MODE_OS_ON) begin
				next_clutch = 1'b0;
				next_seq    = VCL_SEQ_IDLE;
			end else if (mode_eval == VCL_MODE_OS_ON && mode_chg &&
				!cmd && clutch) begin
				next_clutch = 1'b0;
				next_seq    = VCL_SEQ_IDLE;
			end else if (start || seq != VCL_SEQ_IDLE) begin
				// Command falls are not looked at here
				next_acc = acc_sum;
				case (seq)
					VCL_SEQ_IDLE, VCL_SEQ_PRE: begin
						if (pre_hit) begin
							next_acc = acc_post;
							if (post_hit) begin
								next_clutch = 1'b0;
								next_seq    = VCL_SEQ_IDLE;
							end else begin
								next_clutch = 1'b1;
								next_seq    = VCL_SEQ_POST;
							end
						end else begin
							next_clutch = 1'b0;
							next_seq    = VCL_SEQ_PRE;
						end
					end
					VCL_SEQ_POST: begin
						if (post_hit) begin
							next_clutch = 1'b0;
							next_seq    = VCL_SEQ_IDLE;
						end
					end
					default: begin
						next_clutch = 1'b0;
						next_seq    = VCL_SEQ_IDLE;
					end
				endcase
			end else if (mode_eval == VCL_MODE_OS_NO) begin
				next_clutch = 1'b0;
			end
		end else begin
			// Modes outside this block hold the clutch state and clear the sequence
			next_seq = VCL_SEQ_IDLE;
		end
	end

	// Operation-cycle state; everything advances only on the tick
	always_ff @(posedge REF_CLK or negedge RSTN) begin
		if (!RSTN) begin
			mode_acc <= VCL_MODE_ONOFF;
			mode_err <= 1'b0;
			cmd_prev <= 1'b0;
			err_hold <= 1'b0;
			clutch   <= 1'b0;
			status   <= 1'b0;
			last_cur <= 32'sh0000_0000;
			acc      <= 34'sh0_0000_0000;
			seq      <= VCL_SEQ_IDLE;
			latched  <= '{on_set: VCL_SET_RST, off_set: VCL_SET_RST};
		end else if (OP_TICK) begin
			mode_acc <= mode_eval;
			mode_err <= !mode_ok;
			cmd_prev <= cmd;
			err_hold <= next_err_hold;
			clutch   <= next_clutch;
			status   <= next_clutch;
			last_cur <= CUR_VALUE;
			acc      <= next_acc;
			seq      <= next_seq;
			if (start)
				latched <= setting;
		end
	end

	// Status word and one-cycle-late read data
	assign status_word = {16'h0000, 5'h00, mode_acc, 3'h0,
		(seq != VCL_SEQ_IDLE), err_hold, mode_err, status, clutch};

	assign next_rdata =
		(bus.addr == VCL_ADR_MODE)    ? {16'h0000, mode_word} :
		(bus.addr == VCL_ADR_CTRL)    ? {30'h0000_0000, err_off, cmd} :
		(bus.addr == VCL_ADR_ON_SET)  ? setting.on_set :
		(bus.addr == VCL_ADR_OFF_SET) ? setting.off_set :
		(bus.addr == VCL_ADR_STATUS)  ? status_word : 32'h0000_0000;

	always_ff @(posedge REF_CLK or negedge RSTN) begin
		if (!RSTN)
			rdata <= 32'h0000_0000;
		else if (bus.rd)
			rdata <= next_rdata;
		else
			rdata <= 32'h0000_0000;
	end

	assign RDATA         = rdata;
	assign CLUTCH_ON     = clutch;
	assign CLUTCH_STATUS = status;

	// Checks

	property p_mode_err;
		@(posedge REF_CLK) disable iff (!RSTN)
		(OP_TICK && mode_word > VCL_MODE_MAX) |=>
			(mode_acc == $past(mode_acc)) && mode_err;
	endproperty
	a_mode_err: assert property (p_mode_err)
		else $error("illegal mode word changed the accepted mode");

	property p_status_hold;
		@(posedge REF_CLK) disable iff (!RSTN)
		!OP_TICK |=> $stable(CLUTCH_STATUS);
	endproperty
	a_status_hold: assert property (p_status_hold)
		else $error("status flag moved between ticks");

	property p_status_follow;
		@(posedge REF_CLK) disable iff (!RSTN)
		OP_TICK |=> (CLUTCH_STATUS == CLUTCH_ON);
	endproperty
	a_status_follow: assert property (p_status_follow)
		else $error("status flag not refreshed from clutch state");

	property p_err_off;
		@(posedge REF_CLK) disable iff (!RSTN)
		(OP_TICK && err_off && MAJOR_ERR) |=> !CLUTCH_ON ##1 !CLUTCH_ON;
	endproperty
	a_err_off: assert property (p_err_off)
		else $error("clutch not forced off on major error");

	property p_mode2_low;
		@(posedge REF_CLK) disable iff (!RSTN)
		(OP_TICK && mode_eval == VCL_MODE_ADR2 && !cmd) |=> !CLUTCH_ON;
	endproperty
	a_mode2_low: assert property (p_mode2_low)
		else $error("mode 2 clutch on with command low");

	property p_mode4_off;
		@(posedge REF_CLK) disable iff (!RSTN)
		(OP_TICK && mode_eval == VCL_MODE_OS_NO &&
			mode_acc != VCL_MODE_OS_ON && mode_acc != VCL_MODE_OS_NO &&
			!next_err_hold) |=> !CLUTCH_ON && (seq == VCL_SEQ_IDLE);
	endproperty
	a_mode4_off: assert property (p_mode4_off)
		else $error("entry to mode 4 left the clutch on");

	sequence s_zero_pre_start;
		OP_TICK && start && (setting.off_set == 32'sh0000_0000) &&
			(setting.on_set != 32'sh0000_0000) && !next_err_hold;
	endsequence

	property p_zero_pre;
		@(posedge REF_CLK) disable iff (!RSTN)
		s_zero_pre_start |=> CLUTCH_ON && (seq == VCL_SEQ_POST);
	endproperty
	a_zero_pre: assert property (p_zero_pre)
		else $error("zero pre distance did not engage at once");

	sequence s_pre_wait;
		OP_TICK && seq == VCL_SEQ_PRE && !pre_hit &&
			mode_eval == VCL_MODE_OS_ON && !mode_chg && !next_err_hold;
	endsequence

	property p_pre_wait;
		@(posedge REF_CLK) disable iff (!RSTN)
		s_pre_wait |=> (seq == VCL_SEQ_PRE) && !CLUTCH_ON &&
			(latched == $past(latched));
	endproperty
	a_pre_wait: assert property (p_pre_wait)
		else $error("pending sequence disturbed before its distance");

	property p_read_status;
		@(posedge REF_CLK) disable iff (!RSTN)
		(RD && ADDR == VCL_ADR_STATUS) |=>
			(RDATA[VCL_ST_CLUTCH] == $past(clutch)) &&
			(RDATA[VCL_ST_FLAG] == $past(status));
	endproperty
	a_read_status: assert property (p_read_status)
		else $error("status read does not show clutch state");
endmodule
`default_nettype wire
